//--- lcc_defines.vh
// Offsets, field positions, reset values and codes of the lane config bank
`ifndef LCC_DEFINES_VH
`define LCC_DEFINES_VH

// Register offsets (byte addresses on the register port)
`define LCC_ADDR_BOOST 8'h1d
`define LCC_ADDR_SWING 8'h1e
`define LCC_ADDR_EMPH 8'h1f
`define LCC_ADDR_THRESH 8'h20
`define LCC_ADDR_QSPEED 8'h23

// Reset values
`define LCC_RST_BOOST 8'h20
`define LCC_RST_SWING 8'h03
`define LCC_RST_EMPH 8'h03
`define LCC_RST_THRESH 8'h00
`define LCC_RST_QSPEED 8'h00

// Input boost field layout
`define LCC_EQ_EN_BIT 5
`define LCC_GST_HI 4
`define LCC_GST_LO 3
`define LCC_BST_HI 2
`define LCC_BST_LO 0
`define LCC_EQ_BYPASS 6'h20

// Output swing field and codes
`define LCC_SWING_HI 6
`define LCC_SWING_600 7'h03
`define LCC_SWING_800 7'h07
`define LCC_SWING_1000 7'h0f
`define LCC_SWING_1200 7'h1f
`define LCC_SWING_1400 7'h3f

// Output emphasis style bit and codes
`define LCC_EMPH_STYLE_BIT 7
`define LCC_EMPH_0DB 8'h01
`define LCC_EMPH_9DB 8'h90
`define LCC_EMPH_12DB 8'ha0
`define LCC_EMPH_RSVD 8'hc0

// Idle threshold field layout
`define LCC_DEASSERT_HI 3
`define LCC_DEASSERT_LO 2
`define LCC_ASSERT_HI 1
`define LCC_ASSERT_LO 0

// Idle and rate select bits
`define LCC_IDLE_AUTO_BIT 5
`define LCC_IDLE_MUTE_BIT 4
`define LCC_RATE_AUTO_BIT 1
`define LCC_RATE_SEL_BIT 0

// Strap pin equivalents: low, high, floating
`define LCC_STRAP_LOW 2'h0
`define LCC_STRAP_HIGH 2'h1
`define LCC_STRAP_FLOAT 2'h2

`endif

//--- lcc_boost_decode.v
// Input boost code decode to strap equivalent and strap match flag
`timescale 1ns/1ps
`include "lcc_defines.vh"

module lcc_boost_decode (
   input wire [5:0] boost_code,
   output reg strap_match,
   output reg [1:0] boost_strap_high,
   output reg [1:0] boost_strap_low
);

   // ----------------------------------------------------------------
   // Strap lookup
   // ----------------------------------------------------------------
   // Codes with no strap twin report no match; straps read low then
   always @* begin
      strap_match = 1'b1;
      boost_strap_high = `LCC_STRAP_LOW;
      boost_strap_low = `LCC_STRAP_LOW;
      case (boost_code)
         6'h20: begin
            boost_strap_high = `LCC_STRAP_FLOAT;
            boost_strap_low = `LCC_STRAP_FLOAT;
         end
         6'h2a: begin
            boost_strap_high = `LCC_STRAP_HIGH;
            boost_strap_low = `LCC_STRAP_HIGH;
         end
         6'h30: begin
            boost_strap_high = `LCC_STRAP_LOW;
            boost_strap_low = `LCC_STRAP_LOW;
         end
         6'h32: begin
            boost_strap_high = `LCC_STRAP_FLOAT;
            boost_strap_low = `LCC_STRAP_LOW;
         end
         6'h39: begin
            boost_strap_high = `LCC_STRAP_HIGH;
            boost_strap_low = `LCC_STRAP_LOW;
         end
         6'h35: begin
            boost_strap_high = `LCC_STRAP_FLOAT;
            boost_strap_low = `LCC_STRAP_HIGH;
         end
         6'h37: begin
            boost_strap_high = `LCC_STRAP_LOW;
            boost_strap_low = `LCC_STRAP_HIGH;
         end
         6'h3b: begin
            boost_strap_high = `LCC_STRAP_LOW;
            boost_strap_low = `LCC_STRAP_FLOAT;
         end
         6'h3d: begin
            boost_strap_high = `LCC_STRAP_HIGH;
            boost_strap_low = `LCC_STRAP_FLOAT;
         end
         default: begin
            strap_match = 1'b0;
         end
      endcase
   end

endmodule // lcc_boost_decode

//--- lcc_config_regs.v
// Lane conditioning register slice: boost, swing, emphasis, idle, rate
`timescale 1ns/1ps
`include "lcc_defines.vh"

module lcc_config_regs (
   input wire clk,
   input wire rst,
   // Register port
   input wire [7:0] addr,
   input wire [7:0] wr_data,
   input wire wr_en,
   input wire rd_en,
   output wire [7:0] rd_data,
   // Status from the analog lane, asynchronous to clk
   input wire quiet_detected,
   input wire rate_detected_5g,
   // Input boost controls
   output wire boost_enable,
   output wire [1:0] gain_stage_field,
   output wire [2:0] boost_level_field,
   output wire boost_bypass,
   output wire boost_strap_match,
   output wire [1:0] boost_strap_high,
   output wire [1:0] boost_strap_low,
   // Output swing controls
   output wire [6:0] output_swing_setting,
   output wire [10:0] swing_mv,
   output wire swing_code_known,
   // Output emphasis controls
   output wire emphasis_style,
   output wire [6:0] emphasis_level,
   output wire [7:0] emphasis_atten_tenth_db,
   output wire emphasis_code_known,
   output wire emphasis_code_reserved,
   // Idle threshold controls
   output wire [7:0] deassert_mv,
   output wire [7:0] assert_mv,
   // Idle and rate controls of the third lane
   output wire signal_presence_detect,
   output wire output_muted,
   output wire rate_auto_active,
   output wire rate_is_5g
);

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------

   // Threshold selection to millivolts; used for both levels
   function [7:0] lcc_thresh_mv;
      input [1:0] sel;
      input is_deassert;
      begin
         case (sel)
            2'h0: lcc_thresh_mv = is_deassert ? 8'd110 : 8'd70;
            2'h1: lcc_thresh_mv = is_deassert ? 8'd150 : 8'd110;
            2'h2: lcc_thresh_mv = is_deassert ? 8'd170 : 8'd130;
            default: lcc_thresh_mv = is_deassert ? 8'd190 : 8'd150;
         endcase
      end
   endfunction

   // Address match against one register offset
   function lcc_hit;
      input [7:0] a;
      input [7:0] offset;
      begin
         lcc_hit = (a == offset);
      end
   endfunction

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   // All eight bits are kept, reserved ones too: the table marks the
   // whole byte read/write, so software sees back what it wrote.
   reg [7:0] boost_reg;
   reg [7:0] swing_reg;
   reg [7:0] emph_reg;
   reg [7:0] thresh_reg;
   reg [7:0] qspeed_reg;
   reg [7:0] rd_data_reg;
   reg [7:0] rd_data_next;

   // Synchroniser stages for the two lane status inputs
   reg [1:0] sync_a_reg;
   reg [1:0] sync_b_reg;
   wire [1:0] lane_status;

   // ----------------------------------------------------------------
   // Write side
   // ----------------------------------------------------------------

   // Input boost register; reset value is the bypass code
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         boost_reg <= `LCC_RST_BOOST;
      end else if (wr_en && lcc_hit(addr, `LCC_ADDR_BOOST)) begin
         boost_reg <= wr_data;
      end
   end

   // Output swing register; reset value is the 600 mV code
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         swing_reg <= `LCC_RST_SWING;
      end else if (wr_en && lcc_hit(addr, `LCC_ADDR_SWING)) begin
         swing_reg <= wr_data;
      end
   end

   // Output emphasis register; the reserved code is stored as written,
   // but flagged so the analog side can ignore it
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         emph_reg <= `LCC_RST_EMPH;
      end else if (wr_en && lcc_hit(addr, `LCC_ADDR_EMPH)) begin
         emph_reg <= wr_data;
      end
   end

   // Idle threshold register; reset gives the lowest level pair
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         thresh_reg <= `LCC_RST_THRESH;
      end else if (wr_en && lcc_hit(addr, `LCC_ADDR_THRESH)) begin
         thresh_reg <= wr_data;
      end
   end

   // Idle and rate select register of the third lane
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         qspeed_reg <= `LCC_RST_QSPEED;
      end else if (wr_en && lcc_hit(addr, `LCC_ADDR_QSPEED)) begin
         qspeed_reg <= wr_data;
      end
   end

   // ----------------------------------------------------------------
   // Read side
   // ----------------------------------------------------------------

   // Read mux; unmapped offsets answer zero and writes to them vanish
   always @* begin
      rd_data_next = 8'h00;
      case (addr)
         `LCC_ADDR_BOOST: rd_data_next = boost_reg;
         `LCC_ADDR_SWING: rd_data_next = swing_reg;
         `LCC_ADDR_EMPH: rd_data_next = emph_reg;
         `LCC_ADDR_THRESH: rd_data_next = thresh_reg;
         `LCC_ADDR_QSPEED: rd_data_next = qspeed_reg;
         default: rd_data_next = 8'h00;
      endcase
   end

   // Read data stands only in the cycle after the strobe, else zero.
   // A read beside a write to the same offset returns the old value.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_data_reg <= 8'h00;
      end else if (rd_en) begin
         rd_data_reg <= rd_data_next;
      end else begin
         rd_data_reg <= 8'h00;
      end
   end

   assign rd_data = rd_data_reg;

   // ----------------------------------------------------------------
   // Lane status synchronisers
   // ----------------------------------------------------------------
   // Both inputs come from the analog lane with no clock relation, so
   // each passes two flops; only the second stage is read.
   wire [1:0] lane_raw;
   assign lane_raw = {rate_detected_5g, quiet_detected};

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
         always @(posedge clk or posedge rst) begin
            if (rst) begin
               sync_a_reg[gi] <= 1'b0;
               sync_b_reg[gi] <= 1'b0;
            end else begin
               sync_a_reg[gi] <= lane_raw[gi];
               sync_b_reg[gi] <= sync_a_reg[gi];
            end
         end
      end
   endgenerate

   assign lane_status = sync_b_reg;

   // ----------------------------------------------------------------
   // Input boost decode
   // ----------------------------------------------------------------

   // Field split of the six-bit boost code
   assign boost_enable = boost_reg[`LCC_EQ_EN_BIT];
   assign gain_stage_field =
      boost_reg[`LCC_GST_HI:`LCC_GST_LO];
   assign boost_level_field =
      boost_reg[`LCC_BST_HI:`LCC_BST_LO];

   // Bypass is the reset code exactly; other codes apply boost
   assign boost_bypass =
      (boost_reg[5:0] == `LCC_EQ_BYPASS);

   // Strap-equivalent lookup lives in its own decoder
   lcc_boost_decode u_boost_decode (
      .boost_code(boost_reg[5:0]),
      .strap_match(boost_strap_match),
      .boost_strap_high(boost_strap_high),
      .boost_strap_low(boost_strap_low)
   );

   // ----------------------------------------------------------------
   // Output swing decode
   // ----------------------------------------------------------------
   reg [10:0] swing_mv_next;
   reg swing_known_next;

   // Only the five listed codes have a defined amplitude; anything
   // else is flagged unknown and reported as zero millivolts.
   always @* begin
      swing_known_next = 1'b1;
      case (swing_reg[`LCC_SWING_HI:0])
         `LCC_SWING_600: swing_mv_next = 11'd600;
         `LCC_SWING_800: swing_mv_next = 11'd800;
         `LCC_SWING_1000: swing_mv_next = 11'd1000;
         `LCC_SWING_1200: swing_mv_next = 11'd1200;
         `LCC_SWING_1400: swing_mv_next = 11'd1400;
         default: begin
            swing_mv_next = 11'd0;
            swing_known_next = 1'b0;
         end
      endcase
   end

   assign output_swing_setting = swing_reg[`LCC_SWING_HI:0];
   assign swing_mv = swing_mv_next;
   assign swing_code_known = swing_known_next;

   // ----------------------------------------------------------------
   // Output emphasis decode
   // ----------------------------------------------------------------
   reg [7:0] emph_atten_next;
   reg emph_known_next;

   // Attenuation in tenths of a dB for the defined codes
   always @* begin
      emph_known_next = 1'b1;
      case (emph_reg)
         `LCC_EMPH_0DB: emph_atten_next = 8'd0;
         `LCC_EMPH_9DB: emph_atten_next = 8'd90;
         `LCC_EMPH_12DB: emph_atten_next = 8'd120;
         default: begin
            emph_atten_next = 8'd0;
            emph_known_next = 1'b0;
         end
      endcase
   end

   // Style bit: zero compatibility, one enhanced
   assign emphasis_style =
      emph_reg[`LCC_EMPH_STYLE_BIT];
   assign emphasis_level = emph_reg[6:0];
   assign emphasis_atten_tenth_db = emph_atten_next;
   assign emphasis_code_known = emph_known_next;

   // The host must avoid this code; it is only reported, not blocked
   assign emphasis_code_reserved =
      (emph_reg == `LCC_EMPH_RSVD);

   // ----------------------------------------------------------------
   // Idle threshold decode
   // ----------------------------------------------------------------
   wire [1:0] deassert_sel;
   wire [1:0] assert_sel;

   assign deassert_sel =
      thresh_reg[`LCC_DEASSERT_HI:`LCC_DEASSERT_LO];
   assign assert_sel =
      thresh_reg[`LCC_ASSERT_HI:`LCC_ASSERT_LO];

   // Same table for both levels, picked by the second argument
   assign deassert_mv = lcc_thresh_mv(deassert_sel, 1'b1);
   assign assert_mv = lcc_thresh_mv(assert_sel, 1'b0);

   // ----------------------------------------------------------------
   // Idle control of the third lane
   // ----------------------------------------------------------------
   wire idle_auto;
   wire idle_mute;

   assign idle_auto = qspeed_reg[`LCC_IDLE_AUTO_BIT];
   assign idle_mute = qspeed_reg[`LCC_IDLE_MUTE_BIT];

   // Presence detection runs only in automatic mode; manual mode with
   // the mute bit clear keeps the output on and detection off.
   assign signal_presence_detect = idle_auto;

   // Automatic mode follows the lane's own quiet detector; manual mode
   // obeys the mute bit. The detector reaches here two cycles late.
   assign output_muted = idle_auto ? lane_status[0]
                                   : idle_mute;

   // ----------------------------------------------------------------
   // Rate control of the third lane
   // ----------------------------------------------------------------
   wire rate_auto;
   wire rate_manual_5g;

   assign rate_auto = qspeed_reg[`LCC_RATE_AUTO_BIT];
   assign rate_manual_5g = qspeed_reg[`LCC_RATE_SEL_BIT];

   assign rate_auto_active = rate_auto;

   // Zero in the manual bit is 2.5 Gbps, one is 5.0 Gbps
   assign rate_is_5g = rate_auto ? lane_status[1]
                                 : rate_manual_5g;

   // Reserved bits of every register are stored and read back as the
   // host wrote them; no logic above looks at them.

endmodule // lcc_config_regs

//--- lcc_config_regs_assertions.sv
// Concurrent checks on the ports of the lane conditioning register slice
`timescale 1ns/1ps
module lcc_config_regs_chk (
   input wire clk,
   input wire rst,
   input wire [7:0] addr,
   input wire [7:0] wr_data,
   input wire wr_en,
   input wire rd_en,
   input wire [7:0] rd_data,
   input wire quiet_detected,
   input wire rate_detected_5g,
   input wire boost_bypass,
   input wire [6:0] output_swing_setting,
   input wire [10:0] swing_mv,
   input wire emphasis_style,
   input wire [6:0] emphasis_level,
   input wire [7:0] emphasis_atten_tenth_db,
   input wire [7:0] deassert_mv,
   input wire [7:0] assert_mv,
   input wire signal_presence_detect,
   input wire output_muted,
   input wire rate_auto_active,
   input wire rate_is_5g
);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // Write data bits pulled out so that $past sees plain signals
   wire byp_code = (wr_data[5:0] == 6'h20);
   wire mute_bit = wr_data[4];
   wire rate_bit = wr_data[0];
   // Threshold levels in mV: 110/150/170/190 and 70/110/130/150
   function automatic [7:0] dmv(input [7:0] r);
      dmv = (r[3:2] == 2'h0) ? 8'h6e : 8'h82 + 8'h14 * r[3:2];
   endfunction
   function automatic [7:0] amv(input [7:0] r);
      amv = (r[1:0] == 2'h0) ? 8'h46 : 8'h5a + 8'h14 * r[1:0];
   endfunction
   sequence wr_to(a);
      wr_en && addr == a;
   endsequence
   // Sync flops need the detect level held for three samples
   sequence quiet_held;
      (signal_presence_detect && quiet_detected)[*3]
         ##1 signal_presence_detect;
   endsequence
   sequence rate_held;
      (rate_auto_active && rate_detected_5g)[*3]
         ##1 rate_auto_active;
   endsequence
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   boost_bypass_a: assert property (
      wr_to(8'h1d) |=> boost_bypass == $past(byp_code))
      else $error("bypass flag wrong after boost write");
   swing_store_a: assert property (
      wr_to(8'h1e) |=>
      {1'b0, output_swing_setting} == ($past(wr_data) & 8'h7f))
      else $error("swing field not stored");
   swing_mv_a: assert property (
      output_swing_setting == 7'h07 |-> swing_mv == 11'h320)
      else $error("swing code 07 not 800 mV");
   emph_style_a: assert property (
      wr_to(8'h1f) |=>
      {emphasis_style, emphasis_level} == $past(wr_data))
      else $error("emphasis style or level not stored");
   emph_level_a: assert property (
      {emphasis_style, emphasis_level} == 8'ha0 |->
      emphasis_atten_tenth_db == 8'h78)
      else $error("emphasis a0 not 12 dB");
   thresh_map_a: assert property (
      wr_to(8'h20) |=> deassert_mv == dmv($past(wr_data)) &&
      assert_mv == amv($past(wr_data)))
      else $error("threshold levels wrong");
   idle_manual_a: assert property (
      wr_en && addr == 8'h23 && !wr_data[5] |=>
      !signal_presence_detect && output_muted == $past(mute_bit))
      else $error("manual mute not obeyed");
   idle_auto_a: assert property (quiet_held |-> output_muted)
      else $error("auto idle did not mute");
   rate_manual_a: assert property (
      wr_en && addr == 8'h23 && !wr_data[1] |=>
      rate_is_5g == $past(rate_bit))
      else $error("manual rate not obeyed");
   rate_auto_a: assert property (rate_held |-> rate_is_5g)
      else $error("auto rate did not follow detect");
   read_idle_a: assert property (
      !$past(rd_en) |-> rd_data == 8'h00)
      else $error("read data outside read slot");
   read_swing_a: assert property (
      rd_en && addr == 8'h1e |=> rd_data[6:0] == output_swing_setting)
      else $error("swing read back wrong");
endmodule // lcc_config_regs_chk

bind lcc_config_regs lcc_config_regs_chk chk (.clk, .rst, .addr, .wr_data,
   .wr_en, .rd_en, .rd_data, .quiet_detected, .rate_detected_5g, .boost_bypass,
   .output_swing_setting, .swing_mv, .emphasis_style, .emphasis_level,
   .emphasis_atten_tenth_db, .deassert_mv, .assert_mv, .signal_presence_detect,
   .output_muted, .rate_auto_active, .rate_is_5g);

//--- lcc_host_model.sv
// Management host model driving the register port
`timescale 1ns/1ps
module lcc_host_model (
   input wire clk,
   output logic [7:0] addr,
   output logic [7:0] wr_data,
   output logic wr_en,
   output logic rd_en,
   input wire [7:0] rd_data
);
   // Idle bus from time zero
   initial begin
      addr = 8'h00;
      wr_data = 8'h00;
      wr_en = 1'b0;
      rd_en = 1'b0;
   end
   // One strobe cycle launched on an edge; the trailing step lets the
   // decodes settle before the caller looks at them
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      #1;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      d = rd_data;
   endtask
endmodule // lcc_host_model

//--- test_lane_conditioning_config_regs.sv
// Self-checking bench of the lane conditioning register slice
`timescale 1ns/1ps
`include "lcc_defines.vh"
module test_lane_conditioning_config_regs;
   // ----------------------------------------
   // Signals and design
   // ----------------------------------------
   logic clk, rst, quiet_detected, rate_detected_5g;
   wire [7:0] addr, wr_data, rd_data, emphasis_atten_tenth_db;
   wire [7:0] deassert_mv, assert_mv;
   wire wr_en, rd_en, boost_enable, boost_bypass, boost_strap_match;
   wire [1:0] gain_stage_field, boost_strap_high, boost_strap_low;
   wire [2:0] boost_level_field;
   wire [6:0] output_swing_setting, emphasis_level;
   wire [10:0] swing_mv;
   wire swing_code_known, emphasis_style, emphasis_code_known;
   wire emphasis_code_reserved, signal_presence_detect, output_muted;
   wire rate_auto_active, rate_is_5g;
   // Grouped outputs so each compare fits on one line with its tag
   wire [5:0] boost_fields =
      {boost_enable, gain_stage_field, boost_level_field};
   wire [3:0] straps = {boost_strap_high, boost_strap_low};
   integer fails, n_tests, cycles, i;
   logic [7:0] d;
   logic [7:0] bc[9] = '{8'h20, 8'h2a, 8'h30, 8'h32, 8'h39, 8'h35, 8'h37,
      8'h3b, 8'h3d};
   // Strap pairs {high, low}: 0 low, 1 high, 2 floating
   logic [3:0] sp[9] = '{4'ha, 4'h5, 4'h0, 4'h8, 4'h4, 4'h9, 4'h1, 4'h2, 4'h6};
   logic [7:0] sc[5] = '{8'h03, 8'h07, 8'h0f, 8'h1f, 8'h3f};
   // 600 to 1400 mV
   logic [10:0] mv[5] = '{11'h258, 11'h320, 11'h3e8, 11'h4b0, 11'h578};
   logic [7:0] ec[4] = '{8'h01, 8'h90, 8'ha0, 8'hc0};
   logic [7:0] at[4] = '{8'h00, 8'h5a, 8'h78, 8'h00};
   logic [7:0] dm[4] = '{8'h6e, 8'h96, 8'haa, 8'hbe};
   logic [7:0] am[4] = '{8'h46, 8'h6e, 8'h82, 8'h96};
   logic [7:0] ra[5] = '{8'h1d, 8'h1e, 8'h1f, 8'h20, 8'h23};
   logic [7:0] rv[5] = '{8'h20, 8'h03, 8'h03, 8'h00, 8'h00};

   lcc_host_model host (.clk, .addr, .wr_data, .wr_en, .rd_en, .rd_data);
   lcc_config_regs DUT (.clk, .rst, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
      .quiet_detected, .rate_detected_5g, .boost_enable, .gain_stage_field,
      .boost_level_field, .boost_bypass, .boost_strap_match, .boost_strap_high,
      .boost_strap_low, .output_swing_setting, .swing_mv, .swing_code_known,
      .emphasis_style, .emphasis_level, .emphasis_atten_tenth_db,
      .emphasis_code_known, .emphasis_code_reserved, .deassert_mv, .assert_mv,
      .signal_presence_detect, .output_muted, .rate_auto_active, .rate_is_5g);

   // ----------------------------------------
   // Clock, timeout and reporting
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // The run needs some 115 cycles; a hang ends at cycle 4000
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         fails++;
         tally_and_finish;
      end
   end
   task automatic chk(input string what, input logic [10:0] exp,
      input logic [10:0] got);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task tally_and_finish;
      $display("Comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      rst = 1'b1;
      quiet_detected = 1'b0;
      rate_detected_5g = 1'b0;
      fails = 0;
      n_tests = 0;
      cycles = 0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      // Reset values, then the decodes they imply
      for (i = 0; i < 5; i++) begin
         host.rd(ra[i], d);
         chk("reset value", rv[i], d);
      end
      chk("bypass", 1, boost_bypass);
      chk("swing mv", 11'h258, swing_mv);
      chk("deassert", 8'h6e, deassert_mv);
      chk("assert", 8'h46, assert_mv);
      $display("reset test done");
      // Every strap-equivalent boost code, then one outside the list
      for (i = 0; i < 9; i++) begin
         host.wr(`LCC_ADDR_BOOST, bc[i]);
         chk("strap pins", sp[i], straps);
         chk("strap match", 1, boost_strap_match);
         chk("boost fields", bc[i], boost_fields);
         chk("bypass", bc[i] == 8'h20, boost_bypass);
      end
      host.wr(`LCC_ADDR_BOOST, 8'h1f);
      chk("strap match", 0, boost_strap_match);
      $display("boost test done");
      // Swing codes and an unlisted code
      for (i = 0; i < 5; i++) begin
         host.wr(`LCC_ADDR_SWING, sc[i]);
         chk("swing mv", mv[i], swing_mv);
         chk("swing known", 1, swing_code_known);
      end
      host.wr(`LCC_ADDR_SWING, 8'h05);
      chk("swing known", 0, swing_code_known);
      host.rd(`LCC_ADDR_SWING, d);
      chk("swing read", 8'h05, d);
      $display("swing test done");
      // Emphasis codes, the reserved one last
      for (i = 0; i < 4; i++) begin
         host.wr(`LCC_ADDR_EMPH, ec[i]);
         chk("emph atten", at[i], emphasis_atten_tenth_db);
         chk("emph style", ec[i][7], emphasis_style);
         chk("emph known", i < 3, emphasis_code_known);
         chk("emph reserved", i == 3, emphasis_code_reserved);
      end
      $display("emphasis test done");
      // All sixteen threshold pairs
      for (i = 0; i < 16; i++) begin
         host.wr(`LCC_ADDR_THRESH, i[7:0]);
         chk("deassert", dm[i[3:2]], deassert_mv);
         chk("assert", am[i[1:0]], assert_mv);
      end
      $display("threshold test done");
      // Manual idle and rate, both values of each bit
      host.wr(`LCC_ADDR_QSPEED, 8'h11);
      chk("muted", 1, output_muted);
      chk("rate 5g", 1, rate_is_5g);
      chk("presence", 0, signal_presence_detect);
      host.wr(`LCC_ADDR_QSPEED, 8'h00);
      chk("muted", 0, output_muted);
      chk("rate 5g", 0, rate_is_5g);
      chk("rate auto", 0, rate_auto_active);
      // Automatic modes follow the lane detectors through the sync flops
      host.wr(`LCC_ADDR_QSPEED, 8'h22);
      @(posedge clk);
      quiet_detected <= 1'b1;
      rate_detected_5g <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk("auto muted", 1, output_muted);
      chk("auto rate", 1, rate_is_5g);
      chk("rate auto", 1, rate_auto_active);
      chk("presence", 1, signal_presence_detect);
      @(posedge clk);
      quiet_detected <= 1'b0;
      rate_detected_5g <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk("auto muted", 0, output_muted);
      chk("auto rate", 0, rate_is_5g);
      $display("idle rate test done");
      // Unmapped access and back-to-back readback
      host.wr(8'h21, 8'h5a);
      host.wr(`LCC_ADDR_EMPH, 8'h90);
      host.rd(8'h21, d);
      chk("unmapped read", 8'h00, d);
      host.rd(`LCC_ADDR_EMPH, d);
      chk("emph read", 8'h90, d);
      host.rd(`LCC_ADDR_THRESH, d);
      chk("thresh read", 8'h0f, d);
      host.rd(`LCC_ADDR_QSPEED, d);
      chk("idle rate read", 8'h22, d);
      $display("readback test done");
      tally_and_finish;
   end
endmodule // test_lane_conditioning_config_regs
